// >>> design/tci_defs.svh
// constants for the terminal character interpreter
// Contract
// [RQ1] ordinary keys send their ascii code
// [RQ2] up arrow key sends 1e
// [RQ3] left arrow key sends 1f
// [RQ4] function on capitals, digits sets top bit
// [RQ5] function lower case sent as capital code
// [RQ6] local function keys never reach host
// [RQ7] host sends escape and command separately
// [RQ8] escape a/b/c move up, down, right
// [RQ9] escape d moves left, wraps to prior line
// [RQ10] escape e homes and clears, h homes
// [RQ11] escape j erases to end of screen
// [RQ12] escape k erases to end of line
// [RQ13] escape y: column, row minus 20h
// [RQ14] addressed cursor relative to full screen
// [RQ15] escape 47h enters graphics mode
// [RQ16] graphics: 00h-1eh symbols, 02h/1eh escape
// [RQ17] graphics: 20h-7eh stay ascii characters
// [RQ18] escape 4eh leaves graphics mode
// [RQ19] data bytes pass through port c0h
// [RQ20] handshake flags in upper bits of c2h
// [RQ21] parser returns to text, unknown discarded
`ifndef TCI_DEFS_SVH
`define TCI_DEFS_SVH

// ==========================================================
// port addresses and handshake bit positions
`define TCI_DATA_ADDR    8'hc0
`define TCI_HS_ADDR      8'hc2
`define TCI_HS_KINT_BIT  3
`define TCI_HS_STB_BIT   4
`define TCI_HS_IBF_BIT   5
`define TCI_HS_ACK_BIT   6
`define TCI_HS_OBF_BIT   7

// ==========================================================
// character codes
`define TCI_ESC          8'h1b
`define TCI_ALT_ESC      8'h02
`define TCI_UP_CODE      8'h1e
`define TCI_LEFT_CODE    8'h1f
`define TCI_ADDR_OFFSET  8'h20
`define TCI_PRINT_LO     8'h20
`define TCI_PRINT_HI     8'h7e
`define TCI_SYM_HI       8'h1e
`define TCI_FUNC_BIT     8'h80
`define TCI_CMD_UP       8'h41
`define TCI_CMD_DOWN     8'h42
`define TCI_CMD_RIGHT    8'h43
`define TCI_CMD_LEFT     8'h44
`define TCI_CMD_CLEAR    8'h45
`define TCI_CMD_GFX_ON   8'h47
`define TCI_CMD_HOME     8'h48
`define TCI_CMD_ERA_EOS  8'h4a
`define TCI_CMD_ERA_EOL  8'h4b
`define TCI_CMD_GFX_OFF  8'h4e
`define TCI_CMD_ADDR     8'h59
`define TCI_KEY_TYPEW    8'h31
`define TCI_KEY_SCROLL   8'h53
`define TCI_KEY_INTR     8'h52

// ==========================================================
// reset values
`define TCI_RST_BYTE     8'h00
`define TCI_RST_SPLIT    5'h0c

`endif

// >>> design/tci_pkg.sv
// types of the terminal character interpreter
package tci_pkg;

   // ==========================================================
   // host byte parser states
   typedef enum logic [1:0]
   {
      TCI_ST_TEXT,
      TCI_ST_ESC,
      TCI_ST_COL,
      TCI_ST_ROW
   } tci_state_t;

endpackage : tci_pkg

// >>> design/tci_char_interpreter.sv
// keyboard encoder, host handshake port and escape parser
`timescale 1ns/1ps
`include "tci_defs.svh"

module tci_char_interpreter #(
   parameter int COLS  = 80,
   parameter int ROWS  = 25,
   parameter int COL_W = 7,
   parameter int ROW_W = 5
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // host i/o port
   input  wire logic [7:0]       io_addr,
   input  wire logic             io_rd,
   input  wire logic             io_wr,
   input  wire logic [7:0]       io_wdata,
   output logic      [7:0]       io_rdata,
   output logic                  host_key_irq,
   // keyboard
   input  wire logic             key_valid,
   input  wire logic [7:0]       key_code,
   input  wire logic             key_func,
   input  wire logic             key_arrow_up,
   input  wire logic             key_arrow_left,
   input  wire logic             key_home,
   output logic                  key_ready,
   // local keyboard actions
   output logic                  typewriter_mode,
   output logic                  scroll_fast,
   output logic                  screen_owner_b,
   output logic      [ROW_W-1:0] split_rows,
   output logic                  interrupt_processor_pulse,
   // display
   output logic                  disp_we,
   output logic      [7:0]       disp_char,
   output logic                  disp_gfx,
   output logic      [COL_W-1:0] cursor_col,
   output logic      [ROW_W-1:0] cursor_row,
   output logic                  gfx_mode,
   output logic                  erase_screen,
   output logic                  erase_to_eos,
   output logic                  erase_to_eol
);

   localparam logic [COL_W-1:0] LAST_COL = COL_W'(COLS - 1);
   localparam logic [ROW_W-1:0] LAST_ROW = ROW_W'(ROWS - 1);

   // ==========================================================
   // keyboard side and host read port
   logic [7:0]       key_data_reg, key_data_next;
   logic             ibf_reg, ibf_next;
   logic             stb_reg, stb_next;
   logic             kready_reg, kready_next;
   logic [7:0]       rdata_reg, rdata_next;
   logic             typew_reg, typew_next;
   logic             scroll_reg, scroll_next;
   logic             owner_reg, owner_next;
   logic [ROW_W-1:0] split_reg, split_next;
   logic             intr_reg, intr_next;
   logic [7:0]       enc;
   logic             send;
   logic             ack_reg;
   logic             obf_reg;

   // key translation, local keys, host reads
   always_comb
   begin
      key_data_next = key_data_reg;
      ibf_next      = ibf_reg;
      stb_next      = 1'b0;
      rdata_next    = rdata_reg;
      typew_next    = typew_reg;
      scroll_next   = scroll_reg;
      owner_next    = owner_reg;
      split_next    = split_reg;
      intr_next     = 1'b0;
      enc           = key_code;
      send          = 1'b1;
      // [RQ19] data port read
      if (io_rd && io_addr == `TCI_DATA_ADDR)
      begin
         rdata_next = key_data_reg;
         ibf_next   = 1'b0;
      end
      // [RQ20] handshake flags read
      else if (io_rd && io_addr == `TCI_HS_ADDR)
      begin
         rdata_next = {obf_reg, ack_reg, ibf_reg, stb_reg, ibf_reg, 3'b000};
      end
      else if (io_rd)
      begin
         rdata_next = `TCI_RST_BYTE;
      end
      if (key_valid && !ibf_reg)
      begin
         if (key_func)
         begin
            // [RQ6] local function keys
            if (key_arrow_up)
            begin
               send = 1'b0;
               if (split_reg != LAST_ROW)
                  split_next = split_reg + 1'b1;
            end
            else if (key_arrow_left)
            begin
               send = 1'b0;
               if (split_reg != '0)
                  split_next = split_reg - 1'b1;
            end
            else if (key_home)
            begin
               send       = 1'b0;
               owner_next = !owner_reg;
            end
            else if (key_code == `TCI_KEY_TYPEW)
            begin
               send       = 1'b0;
               typew_next = !typew_reg;
            end
            else if ({key_code[7:6], 1'b0, key_code[4:0]}
                     == `TCI_KEY_SCROLL)
            begin
               send        = 1'b0;
               scroll_next = !scroll_reg;
            end
            else if ({key_code[7:6], 1'b0, key_code[4:0]}
                     == `TCI_KEY_INTR)
            begin
               send      = 1'b0;
               intr_next = 1'b1;
            end
            // [RQ4] capitals and digits
            else if ((key_code >= 8'h41 && key_code <= 8'h5a) ||
                     (key_code >= 8'h30 && key_code <= 8'h39))
               enc = key_code | `TCI_FUNC_BIT;
            // [RQ5] lower case folded
            else if (key_code >= 8'h61 && key_code <= 8'h7a)
               enc = {1'b1, key_code[6], 1'b0, key_code[4:0]};
         end
         // [RQ2] up arrow code
         else if (key_arrow_up)
            enc = `TCI_UP_CODE;
         // [RQ3] left arrow code
         else if (key_arrow_left)
            enc = `TCI_LEFT_CODE;
         // [RQ1] plain ascii passes
         if (send)
         begin
            key_data_next = enc;
            ibf_next      = 1'b1;
            stb_next      = 1'b1;
         end
      end
      kready_next = !ibf_next;
   end

   // keyboard side registers
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         key_data_reg <= `TCI_RST_BYTE;
         ibf_reg      <= 1'b0;
         stb_reg      <= 1'b0;
         kready_reg   <= 1'b0;
         rdata_reg    <= `TCI_RST_BYTE;
         typew_reg    <= 1'b0;
         scroll_reg   <= 1'b0;
         owner_reg    <= 1'b0;
         split_reg    <= `TCI_RST_SPLIT;
         intr_reg     <= 1'b0;
      end
      else
      begin
         key_data_reg <= key_data_next;
         ibf_reg      <= ibf_next;
         stb_reg      <= stb_next;
         kready_reg   <= kready_next;
         rdata_reg    <= rdata_next;
         typew_reg    <= typew_next;
         scroll_reg   <= scroll_next;
         owner_reg    <= owner_next;
         split_reg    <= split_next;
         intr_reg     <= intr_next;
      end
   end

   // ==========================================================
   // host write port and escape parser
   tci_pkg::tci_state_t st_reg, st_next;
   logic [7:0]       hbyte_reg, hbyte_next;
   logic             obf_next, ack_next;
   logic             gfx_reg, gfx_next;
   logic [COL_W-1:0] col_reg, col_next;
   logic [ROW_W-1:0] row_reg, row_next;
   logic             we_reg, we_next;
   logic [7:0]       wch_reg, wch_next;
   logic             wgfx_reg, wgfx_next;
   logic             ers_reg, ers_next;
   logic             eos_reg, eos_next;
   logic             eol_reg, eol_next;
   logic             is_esc;

   // parse the buffered host byte in the cycle after its write
   always_comb
   begin
      st_next    = st_reg;
      hbyte_next = hbyte_reg;
      obf_next   = obf_reg;
      ack_next   = 1'b0;
      gfx_next   = gfx_reg;
      col_next   = col_reg;
      row_next   = row_reg;
      we_next    = 1'b0;
      wch_next   = wch_reg;
      wgfx_next  = wgfx_reg;
      ers_next   = 1'b0;
      eos_next   = 1'b0;
      eol_next   = 1'b0;
      // [RQ16] alternate escapes in graphics
      is_esc = (hbyte_reg == `TCI_ESC) || (gfx_reg &&
               (hbyte_reg == `TCI_ALT_ESC || hbyte_reg == `TCI_UP_CODE));
      // [RQ19] host byte taken into buffer
      if (io_wr && io_addr == `TCI_DATA_ADDR && !obf_reg)
      begin
         obf_next   = 1'b1;
         hbyte_next = io_wdata;
      end
      if (obf_reg)
      begin
         obf_next = 1'b0;
         ack_next = 1'b1;
         unique case (st_reg)
            tci_pkg::TCI_ST_TEXT:
            begin
               // [RQ7] escape opens a command
               if (is_esc)
                  st_next = tci_pkg::TCI_ST_ESC;
               // [RQ16] [RQ17] displayable bytes
               else if ((gfx_reg && hbyte_reg <= `TCI_SYM_HI) ||
                        (hbyte_reg >= `TCI_PRINT_LO &&
                         hbyte_reg <= `TCI_PRINT_HI))
               begin
                  we_next   = 1'b1;
                  wch_next  = hbyte_reg;
                  wgfx_next = hbyte_reg < `TCI_PRINT_LO;
                  if (col_reg >= LAST_COL)
                  begin
                     col_next = '0;
                     if (row_reg < LAST_ROW)
                        row_next = row_reg + 1'b1;
                  end
                  else
                     col_next = col_reg + 1'b1;
               end
            end
            tci_pkg::TCI_ST_ESC:
            begin
               // [RQ21] back to text
               st_next = tci_pkg::TCI_ST_TEXT;
               case (hbyte_reg)
                  // [RQ8] relative moves
                  `TCI_CMD_UP:
                     if (row_reg != '0)
                        row_next = row_reg - 1'b1;
                  `TCI_CMD_DOWN:
                     if (row_reg < LAST_ROW)
                        row_next = row_reg + 1'b1;
                  `TCI_CMD_RIGHT:
                     if (col_reg < LAST_COL)
                        col_next = col_reg + 1'b1;
                  // [RQ9] left with wrap
                  `TCI_CMD_LEFT:
                     if (col_reg != '0)
                        col_next = col_reg - 1'b1;
                     else if (row_reg != '0)
                     begin
                        col_next = LAST_COL;
                        row_next = row_reg - 1'b1;
                     end
                  // [RQ10] home and clear
                  `TCI_CMD_CLEAR:
                  begin
                     col_next = '0;
                     row_next = '0;
                     ers_next = 1'b1;
                  end
                  `TCI_CMD_HOME:
                  begin
                     col_next = '0;
                     row_next = '0;
                  end
                  // [RQ11] erase to end of screen
                  `TCI_CMD_ERA_EOS: eos_next = 1'b1;
                  // [RQ12] erase to end of line
                  `TCI_CMD_ERA_EOL: eol_next = 1'b1;
                  `TCI_CMD_ADDR:    st_next  = tci_pkg::TCI_ST_COL;
                  // [RQ15] graphics on
                  `TCI_CMD_GFX_ON:  gfx_next = 1'b1;
                  // [RQ18] graphics off
                  `TCI_CMD_GFX_OFF: gfx_next = 1'b0;
                  default:          st_next  = tci_pkg::TCI_ST_TEXT;
               endcase
            end
            // [RQ13] [RQ14] offset removed, no clamp
            tci_pkg::TCI_ST_COL:
            begin
               col_next = COL_W'(hbyte_reg - `TCI_ADDR_OFFSET);
               st_next  = tci_pkg::TCI_ST_ROW;
            end
            tci_pkg::TCI_ST_ROW:
            begin
               row_next = ROW_W'(hbyte_reg - `TCI_ADDR_OFFSET);
               st_next  = tci_pkg::TCI_ST_TEXT;
            end
         endcase
      end
   end

   // parser registers
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg    <= tci_pkg::TCI_ST_TEXT;
         hbyte_reg <= `TCI_RST_BYTE;
         obf_reg   <= 1'b0;
         ack_reg   <= 1'b0;
         gfx_reg   <= 1'b0;
         col_reg   <= '0;
         row_reg   <= '0;
         we_reg    <= 1'b0;
         wch_reg   <= `TCI_RST_BYTE;
         wgfx_reg  <= 1'b0;
         ers_reg   <= 1'b0;
         eos_reg   <= 1'b0;
         eol_reg   <= 1'b0;
      end
      else
      begin
         st_reg    <= st_next;
         hbyte_reg <= hbyte_next;
         obf_reg   <= obf_next;
         ack_reg   <= ack_next;
         gfx_reg   <= gfx_next;
         col_reg   <= col_next;
         row_reg   <= row_next;
         we_reg    <= we_next;
         wch_reg   <= wch_next;
         wgfx_reg  <= wgfx_next;
         ers_reg   <= ers_next;
         eos_reg   <= eos_next;
         eol_reg   <= eol_next;
      end
   end

   // outputs straight from flip-flops
   assign io_rdata                  = rdata_reg;
   assign host_key_irq              = ibf_reg;
   assign key_ready                 = kready_reg;
   assign typewriter_mode           = typew_reg;
   assign scroll_fast               = scroll_reg;
   assign screen_owner_b            = owner_reg;
   assign split_rows                = split_reg;
   assign interrupt_processor_pulse = intr_reg;
   assign disp_we                   = we_reg;
   assign disp_char                 = wch_reg;
   assign disp_gfx                  = wgfx_reg;
   assign cursor_col                = col_reg;
   assign cursor_row                = row_reg;
   assign gfx_mode                  = gfx_reg;
   assign erase_screen              = ers_reg;
   assign erase_to_eos              = eos_reg;
   assign erase_to_eol              = eol_reg;

   // ==========================================================
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   logic key_go, cmd_go;
   assign key_go = key_valid && !ibf_reg;
   assign cmd_go = obf_reg && st_reg == tci_pkg::TCI_ST_ESC;

   property p_plain_key;
      key_go && !key_func && !key_arrow_up && !key_arrow_left
      |=> ibf_reg && key_data_reg == $past(key_code);
   endproperty
   a_plain_key: assert property (p_plain_key) // [RQ1]
      else $error("plain key code not delivered");

   property p_up_key;
      key_go && !key_func && key_arrow_up
      |=> key_data_reg == `TCI_UP_CODE ##1 stb_reg == 1'b0;
   endproperty
   a_up_key: assert property (p_up_key) // [RQ2]
      else $error("up arrow code wrong");

   property p_left_key;
      key_go && !key_func && !key_arrow_up && key_arrow_left
      |=> key_data_reg == `TCI_LEFT_CODE && stb_reg;
   endproperty
   a_left_key: assert property (p_left_key) // [RQ3]
      else $error("left arrow code wrong");

   property p_func_cap;
      key_go && key_func && !key_arrow_up && !key_arrow_left &&
      !key_home && key_code >= 8'h41 && key_code <= 8'h51
      |=> key_data_reg == ($past(key_code) | `TCI_FUNC_BIT);
   endproperty
   a_func_cap: assert property (p_func_cap) // [RQ4]
      else $error("function capital code wrong");

   property p_func_lower;
      key_go && key_func && !key_arrow_up && !key_arrow_left &&
      !key_home && key_code >= 8'h61 && key_code <= 8'h71
      |=> key_data_reg == ($past(key_code) - 8'h20 + `TCI_FUNC_BIT);
   endproperty
   a_func_lower: assert property (p_func_lower) // [RQ5]
      else $error("function lower case not folded");

   property p_local_key;
      key_go && key_func && key_home |=> !ibf_reg
      && owner_reg != $past(owner_reg);
   endproperty
   a_local_key: assert property (p_local_key) // [RQ6]
      else $error("local key reached host");

   property p_left_wrap;
      cmd_go && hbyte_reg == `TCI_CMD_LEFT && col_reg == '0 &&
      row_reg != '0 |=> col_reg == LAST_COL
      && row_reg == $past(row_reg) - 1'b1;
   endproperty
   a_left_wrap: assert property (p_left_wrap) // [RQ9]
      else $error("left move did not wrap");

   property p_clear;
      cmd_go && hbyte_reg == `TCI_CMD_CLEAR
      |=> erase_screen && col_reg == '0 && row_reg == '0 ##1 !erase_screen;
   endproperty
   a_clear: assert property (p_clear) // [RQ10]
      else $error("clear screen failed");

   property p_addr;
      obf_reg && st_reg == tci_pkg::TCI_ST_ROW
      |=> row_reg == ROW_W'($past(hbyte_reg) - `TCI_ADDR_OFFSET)
      && st_reg == tci_pkg::TCI_ST_TEXT;
   endproperty
   a_addr: assert property (p_addr) // [RQ13]
      else $error("row address offset wrong");

   property p_gfx_sym;
      obf_reg && st_reg == tci_pkg::TCI_ST_TEXT && gfx_reg &&
      hbyte_reg == 8'h05 |=> disp_we && disp_gfx;
   endproperty
   a_gfx_sym: assert property (p_gfx_sym) // [RQ16]
      else $error("graphics symbol not shown");

   property p_gfx_off;
      cmd_go && hbyte_reg == `TCI_CMD_GFX_OFF |=> !gfx_mode;
   endproperty
   a_gfx_off: assert property (p_gfx_off) // [RQ18]
      else $error("graphics mode not left");

   property p_unknown;
      cmd_go && hbyte_reg == 8'h5a |=> st_reg == tci_pkg::TCI_ST_TEXT
      && !disp_we && $stable(cursor_col) && $stable(cursor_row);
   endproperty
   a_unknown: assert property (p_unknown) // [RQ21]
      else $error("unknown command changed display");

   c_key_sent:   cover property (key_go ##1 io_rd ##1 !ibf_reg);
   c_addr_seq:   cover property (cmd_go && hbyte_reg == `TCI_CMD_ADDR
                                 ##[1:20] st_reg == tci_pkg::TCI_ST_ROW);
   c_gfx_symbol: cover property (disp_we && disp_gfx);
   c_erase_eol:  cover property (erase_to_eol);

endmodule : tci_char_interpreter

// >>> verification/tci_host_model.sv
// host processor model driving the terminal i/o port
`timescale 1ns/1ps
module tci_host_model (
   input  wire logic       core_clk,
   output logic      [7:0] io_addr,
   output logic            io_rd,
   output logic            io_wr,
   output logic      [7:0] io_wdata,
   input  wire logic [7:0] io_rdata
);
   // ==========================================================
   // idle bus at time zero
   initial
   begin
      io_rd    = 1'b0;
      io_wr    = 1'b0;
   end

   // ==========================================================
   // one byte write
   // released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      io_addr  = a;
      io_wdata = d;
      io_wr    = 1'b1;
      @(posedge core_clk);
      #1;
      io_wr    = 1'b0;
      io_addr  = ~a;
      io_wdata = ~d;
      @(posedge core_clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      #1;
      io_addr = a;
      io_rd   = 1'b1;
      @(posedge core_clk);
      #1;
      io_rd   = 1'b0;
      io_addr = ~a;
      @(posedge core_clk);
      #1;
      d = io_rdata;
   endtask : rd

   task automatic esc(input logic [7:0] c);
      wr(8'hc0, 8'h1b);
      wr(8'hc0, c);
   endtask : esc

   task automatic goto(input logic [7:0] col, input logic [7:0] row);
      esc(8'h59);
      wr(8'hc0, col + 8'h20);
      wr(8'hc0, row + 8'h20);
   endtask : goto
endmodule : tci_host_model

// >>> verification/tci_char_interpreter_bench.sv
// self-checking bench of the terminal character interpreter
`timescale 1ns/1ps
module tci_char_interpreter_bench;
   logic       core_clk, rst_n, io_rd, io_wr, host_key_irq, key_ready;
   logic [7:0] io_addr, io_wdata, io_rdata, key_code, disp_char;
   logic       key_valid, key_func, key_arrow_up, key_arrow_left;
   logic       key_home, typewriter_mode, scroll_fast, screen_owner_b;
   logic       interrupt_processor_pulse, disp_we, disp_gfx, gfx_mode;
   logic       erase_screen, erase_to_eos, erase_to_eol;
   logic [6:0] cursor_col;
   logic [4:0] cursor_row, split_rows;
   int         errors = 0, cmp_count = 0, we_cnt = 0, ip_cnt = 0;
   int         scr_cnt = 0, eos_cnt = 0, eol_cnt = 0;

   tci_char_interpreter dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
      .io_wdata(io_wdata), .io_rdata(io_rdata),
      .host_key_irq(host_key_irq), .key_valid(key_valid),
      .key_code(key_code), .key_func(key_func),
      .key_arrow_up(key_arrow_up), .key_arrow_left(key_arrow_left),
      .key_home(key_home), .key_ready(key_ready),
      .typewriter_mode(typewriter_mode), .scroll_fast(scroll_fast),
      .screen_owner_b(screen_owner_b), .split_rows(split_rows),
      .interrupt_processor_pulse(interrupt_processor_pulse),
      .disp_we(disp_we), .disp_char(disp_char), .disp_gfx(disp_gfx),
      .cursor_col(cursor_col), .cursor_row(cursor_row),
      .gfx_mode(gfx_mode), .erase_screen(erase_screen),
      .erase_to_eos(erase_to_eos), .erase_to_eol(erase_to_eol));
   tci_host_model host_u (.core_clk(core_clk), .io_addr(io_addr),
      .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
      .io_rdata(io_rdata));

   // ==========================================================
   // clock and one-cycle pulse counters
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      if (disp_we === 1'b1) we_cnt++;
      if (interrupt_processor_pulse === 1'b1) ip_cnt++;
      if (erase_screen === 1'b1) scr_cnt++;
      if (erase_to_eos === 1'b1) eos_cnt++;
      if (erase_to_eol === 1'b1) eol_cnt++;
   end

   // ==========================================================
   // shared helpers
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic settle;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : settle
   task automatic cur(input logic [7:0] c, input logic [7:0] r);
      chk("cursor_col", c, {1'b0, cursor_col});
      chk("cursor_row", r, {3'b0, cursor_row});
   endtask : cur
   // offer a key, held until the interpreter takes it
   task automatic press(input logic [7:0] c, input logic f, u, l, h);
      int i;
      @(posedge core_clk);
      #1;
      key_valid      = 1'b1;
      key_func       = f;
      key_arrow_up   = u;
      key_arrow_left = l;
      key_home       = h;
      key_code       = c;
      for (i = 0; i < 20 && key_ready !== 1'b1; i++) @(posedge core_clk) #1;
      if (i == 20)
      begin
         errors++;
         tally_and_finish();
      end
      @(posedge core_clk);
      #1;
      key_valid = 1'b0;
      key_code  = ~c;
      settle();
   endtask : press
   task automatic key_chk(input logic [7:0] c, input logic f, u, l,
                          input logic [7:0] e);
      logic [7:0] d;
      press(c, f, u, l, 1'b0);
      chk("key_irq", 8'h01, {7'h0, host_key_irq});
      host_u.rd(8'hc2, d);
      chk("hs_ibf_kint", 8'h28, d & 8'h28);
      host_u.rd(8'hc0, d);
      chk("key_byte", e, d);
      chk("key_irq_clr", 8'h00, {7'h0, host_key_irq});
   endtask : key_chk

   // ==========================================================
   // scenarios
   task automatic t_keys;
      logic [7:0] d;
      key_chk(8'h61, 1'b0, 1'b0, 1'b0, 8'h61);
      key_chk(8'h00, 1'b0, 1'b1, 1'b0, 8'h1e);
      key_chk(8'h00, 1'b0, 1'b0, 1'b1, 8'h1f);
      key_chk(8'h41, 1'b1, 1'b0, 1'b0, 8'hc1);
      key_chk(8'h35, 1'b1, 1'b0, 1'b0, 8'hb5);
      key_chk(8'h62, 1'b1, 1'b0, 1'b0, 8'hc2);
      host_u.rd(8'hc1, d);
      chk("unmapped_read", 8'h00, d);
   endtask : t_keys
   task automatic t_local;
      chk("split_reset", 8'h0c, {3'b0, split_rows});
      press(8'h31, 1'b1, 1'b0, 1'b0, 1'b0);
      chk("typewriter", 8'h01, {7'h0, typewriter_mode});
      press(8'h73, 1'b1, 1'b0, 1'b0, 1'b0);
      chk("scroll_fast", 8'h01, {7'h0, scroll_fast});
      press(8'h00, 1'b1, 1'b0, 1'b0, 1'b1);
      chk("owner_b", 8'h01, {7'h0, screen_owner_b});
      press(8'h00, 1'b1, 1'b1, 1'b0, 1'b0);
      chk("split_up", 8'h0d, {3'b0, split_rows});
      press(8'h00, 1'b1, 1'b0, 1'b1, 1'b0);
      press(8'h00, 1'b1, 1'b0, 1'b1, 1'b0);
      chk("split_down", 8'h0b, {3'b0, split_rows});
      press(8'h72, 1'b1, 1'b0, 1'b0, 1'b0);
      chk("intr_pulses", 8'h01, 8'(ip_cnt));
      chk("local_irq", 8'h00, {7'h0, host_key_irq});
   endtask : t_local
   task automatic t_cursor;
      host_u.goto(8'h0a, 8'h05);
      settle();
      cur(8'h0a, 8'h05);
      host_u.esc(8'h41);
      settle();
      cur(8'h0a, 8'h04);
      host_u.esc(8'h42);
      settle();
      cur(8'h0a, 8'h05);
      host_u.esc(8'h43);
      settle();
      cur(8'h0b, 8'h05);
      host_u.goto(8'h00, 8'h03);
      host_u.esc(8'h44);
      settle();
      cur(8'h4f, 8'h02);
      host_u.goto(8'h00, 8'h18);
      settle();
      cur(8'h00, 8'h18);
      host_u.esc(8'h48);
      settle();
      cur(8'h00, 8'h00);
   endtask : t_cursor
   task automatic t_erase;
      host_u.goto(8'h05, 8'h05);
      host_u.esc(8'h4a);
      settle();
      chk("erase_eos", 8'h01, 8'(eos_cnt));
      host_u.esc(8'h4b);
      settle();
      chk("erase_eol", 8'h01, 8'(eol_cnt));
      host_u.esc(8'h45);
      settle();
      chk("erase_all", 8'h01, 8'(scr_cnt));
      cur(8'h00, 8'h00);
   endtask : t_erase
   task automatic t_gfx;
      int we0;
      host_u.esc(8'h47);
      settle();
      chk("gfx_on", 8'h01, {7'h0, gfx_mode});
      we0 = we_cnt;
      host_u.wr(8'hc0, 8'h05);
      settle();
      chk("sym_char", 8'h05, disp_char);
      chk("sym_gfx", 8'h01, {7'h0, disp_gfx});
      host_u.wr(8'hc0, 8'h41);
      settle();
      chk("ascii_gfx", 8'h00, {7'h0, disp_gfx});
      host_u.wr(8'hc0, 8'h1e);
      host_u.wr(8'hc0, 8'h4e);
      settle();
      chk("gfx_off", 8'h00, {7'h0, gfx_mode});
      chk("gfx_writes", 8'h02, 8'(we_cnt - we0));
      host_u.esc(8'h47);
      host_u.wr(8'hc0, 8'h02);
      host_u.wr(8'hc0, 8'h4e);
      settle();
      chk("alt_esc_off", 8'h00, {7'h0, gfx_mode});
   endtask : t_gfx
   task automatic t_unknown;
      int we0;
      we0 = we_cnt;
      host_u.esc(8'h5a);
      host_u.wr(8'hc1, 8'h41);
      settle();
      chk("no_write", 8'h00, 8'(we_cnt - we0));
      host_u.wr(8'hc0, 8'h41);
      settle();
      chk("text_char", 8'h41, disp_char);
      chk("text_write", 8'h01, 8'(we_cnt - we0));
   endtask : t_unknown

   // ==========================================================
   // verdict and main sequence
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      key_valid = 1'b0;
      rst_n    = 1'b0;
      repeat (12) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      t_keys();
      t_local();
      t_cursor();
      t_erase();
      t_gfx();
      t_unknown();
      tally_and_finish();
   end
endmodule : tci_char_interpreter_bench
